// ==== hdl/qei_map.svh ====
`ifndef QEI_MAP_SVH
`define QEI_MAP_SVH
// register word offsets
`define QEI_CTL_OFS      4'h0
`define QEI_STAT_OFS     4'h1
`define QEI_POS_OFS      4'h2
`define QEI_MAXPOS_OFS   4'h3
`define QEI_LOAD_OFS     4'h4
`define QEI_TIME_OFS     4'h5
`define QEI_COUNT_OFS    4'h6
`define QEI_SPEED_OFS    4'h7
`define QEI_INTEN_OFS    4'h8
`define QEI_RIS_OFS      4'h9
`define QEI_ISC_OFS      4'ha
`define QEI_PINSEL_OFS   4'hb
// control field positions
`define QEI_CTL_EN       0
`define QEI_CTL_SWAP     1
`define QEI_CTL_SIG      2
`define QEI_CTL_CAP      3
`define QEI_CTL_RES      4
`define QEI_CTL_VELEN    5
`define QEI_CTL_DIV_LO   6
`define QEI_CTL_INV_FIRST  9
`define QEI_CTL_INV_SECOND 10
`define QEI_CTL_INV_HOME   11
// interrupt bit positions
`define QEI_INT_HOME     0
`define QEI_INT_TIMER    1
`define QEI_INT_DIR      2
`define QEI_INT_ERR      3
// reset values
`define QEI_CTL_RST      12'h000
`define QEI_WORD_RST     32'h0000_0000
// edges per line for each capture mode
`define QEI_EDGES_CAP0   2
`define QEI_EDGES_CAP1   4
`endif

// ==== hdl/qei_pkg.sv ====
package qei_pkg;
    // control word as software sees it
    typedef struct packed {
        logic       invert_home_pulse;
        logic       invert_second_phase;
        logic       invert_first_phase;
        logic [2:0] speed_prescale_field;
        logic       vel_en;
        logic       counter_wrap_sel;
        logic       edge_capture_sel;
        logic       signal_interpretation_sel;
        logic       swap;
        logic       enable;
    } qei_ctl_t;
    // decoded motion events of one cycle
    typedef struct packed {
        logic step;
        logic down;
        logic dir_change;
        logic phase_err;
        logic home;
    } qei_evt_t;
    // pin samples
    typedef struct packed {
        logic home;
        logic b;
        logic a;
    } qei_pins_t;
endpackage

// ==== hdl/qei_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser, one per encoder pin
module qei_sync
    import qei_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    // pins and result
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    genvar g;
    // meta stage feeds only the second stage
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate
    assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ==== hdl/qei_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
// turns synchronised pins into step, direction and fault events
module qei_decode
    import qei_pkg::*;
(
    // clock and reset
    input  wire logic      mclk_i,
    input  wire logic      resetn_i,
    // configuration and pins
    input  wire qei_ctl_t  ctl_i,
    input  wire logic      run_i,
    input  wire qei_pins_t pins_i,
    // events
    output qei_evt_t       evt_o
);
    qei_pins_t cur;
    qei_pins_t prev_reg, prev_next;
    logic      last_b_reg, last_b_next;
    logic      have_last_reg, have_last_next;
    logic      ea, eb;
    qei_evt_t  evt_c;

    // inversion then swap, ahead of any interpretation
    always_comb begin
        cur.a    = pins_i.a ^ ctl_i.invert_first_phase;
        cur.b    = pins_i.b ^ ctl_i.invert_second_phase;
        cur.home = pins_i.home ^ ctl_i.invert_home_pulse;
        if (ctl_i.swap) begin
            cur.a = pins_i.b ^ ctl_i.invert_second_phase;
            cur.b = pins_i.a ^ ctl_i.invert_first_phase;
        end
    end

    // edges by comparing consecutive synchronised samples
    always_comb begin
        ea = cur.a ^ prev_reg.a;
        eb = cur.b ^ prev_reg.b;
        prev_next      = cur;
        last_b_next    = last_b_reg;
        have_last_next = have_last_reg;
        evt_c          = '0;
        evt_c.home     = run_i && cur.home && !prev_reg.home;
        if (!run_i) begin
            have_last_next = 1'b0;
        end else if (ctl_i.signal_interpretation_sel) begin
            // step on first input rising, level of second is direction
            evt_c.step = cur.a && !prev_reg.a;
            evt_c.down = cur.b;
        end else if (ea && eb) begin
            evt_c.phase_err = 1'b1;
        end else if (ea || eb) begin
            // a leads b: after a moves, a differs from b
            evt_c.down = ea ? (cur.a == cur.b) : (cur.a != cur.b);
            evt_c.step = ea || ctl_i.edge_capture_sel;
            // same phase twice with no edge between means reversal
            evt_c.dir_change = have_last_reg && (last_b_reg == eb);
            last_b_next      = eb;
            have_last_next   = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_reg      <= '0;
            last_b_reg    <= 1'b0;
            have_last_reg <= 1'b0;
            evt_o         <= '0;
        end else begin
            prev_reg      <= prev_next;
            last_b_reg    <= last_b_next;
            have_last_reg <= have_last_next;
            evt_o         <= evt_c;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/qei_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "qei_map.svh"
module qei_top
    import qei_pkg::*;
#(
    parameter int PW = 32
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // encoder pins
    input  wire logic        quad_input_first_i,
    input  wire logic        quad_input_second_i,
    input  wire logic        home_pulse_in_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // interrupt and status
    output logic             irq_o,
    output logic             direction_o
);
    // control and configuration
    qei_ctl_t      ctl_reg;
    qei_ctl_t      ctl_next;
    logic          pin_function_select_reg;
    logic          pinsel_next;
    logic [PW-1:0] position_limit_reg;
    logic [PW-1:0] limit_next;
    logic [31:0]   period_reload_value;
    logic [31:0]   load_next;
    logic [3:0]    inten_reg;
    logic [3:0]    inten_next;
    // position and velocity state
    logic [PW-1:0] pos_reg;
    logic [PW-1:0] pos_next;
    logic [31:0]   timer_reg;
    logic [31:0]   timer_next;
    logic [31:0]   edge_accumulator;
    logic [31:0]   acc_next;
    logic [31:0]   period_edge_result;
    logic [31:0]   speed_next;
    logic [6:0]    pre_reg;
    logic [6:0]    pre_next;
    // status and bus state
    logic [3:0]    ris_reg;
    logic [3:0]    ris_next;
    logic          dir_reg;
    logic          dir_next;
    logic          err_reg;
    logic          err_next;
    logic          ack_reg;
    logic          ack_next;
    logic [31:0]   rdata_reg;
    logic [31:0]   rdata_next;
    // helpers
    logic [31:0]   wmask;
    logic [31:0]   wd;
    qei_pins_t     pins_raw;
    qei_pins_t     pins_sync;
    qei_evt_t      evt;
    logic          run;
    logic          wr_go;
    logic          rd_go;
    logic [6:0]    pre_lim;
    logic          vel_tick;
    logic          expire;
    logic [3:0]    evt_bits;
    logic [3:0]    clr_bits;

    // pins reach the decoder only through the synchroniser
    assign pins_raw = '{home: home_pulse_in_i, b: quad_input_second_i, a: quad_input_first_i};
    qei_sync #(
        .WIDTH (3)
    ) u_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .async_i  (pins_raw),
        .sync_o   (pins_sync)
    );

    // pins stay plain gpio until routed to the decoder
    assign run = ctl_reg.enable && pin_function_select_reg;
    qei_decode u_dec (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .ctl_i    (ctl_reg),
        .run_i    (run),
        .pins_i   (pins_sync),
        .evt_o    (evt)
    );

    // one-cycle answer: waitrequest drops the cycle after the request is seen
    // reads are captured on the stall cycle, writes land on the answer cycle
    assign rd_go = avs_read_i && !ack_reg;
    assign wr_go = avs_write_i && ack_reg;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
        end
    end

    // predivided velocity edge; a field of 0 passes every edge
    // the divider phase survives a period end, so no edge is lost between periods
    assign pre_lim  = 7'((8'h1 << ctl_reg.speed_prescale_field) - 8'h1);
    assign vel_tick = evt.step && ctl_reg.vel_en && run && (pre_reg == pre_lim);
    assign expire   = ctl_reg.vel_en && run && (timer_reg == 32'h0);
    assign evt_bits = {evt.phase_err, evt.dir_change,
                       expire, evt.home};
    assign clr_bits = (wr_go && avs_address_i == `QEI_ISC_OFS) ? avs_writedata_i[3:0] : 4'h0;

    // position, velocity, status and bus next-state
    always_comb begin
        ctl_next    = ctl_reg;
        pinsel_next = pin_function_select_reg;
        pos_next    = pos_reg;
        limit_next  = position_limit_reg;
        load_next   = period_reload_value;
        timer_next  = timer_reg;
        acc_next    = edge_accumulator;
        speed_next  = period_edge_result;
        pre_next    = pre_reg;
        inten_next  = inten_reg;
        dir_next    = dir_reg;
        err_next    = err_reg;
        ack_next    = (avs_read_i || avs_write_i) && !ack_reg;
        rdata_next  = rdata_reg;
        wd          = 32'h0;

        // position integrator
        if (run && evt.step) begin
            dir_next = evt.down;
            // up count wraps at the limit in both modes; a lower limit wraps at once
            if (!evt.down) begin
                if (pos_reg >= position_limit_reg) begin
                    pos_next = '0;
                end else begin
                    pos_next = pos_reg + 1'b1;
                end
            end else if (pos_reg == '0) begin
                pos_next = position_limit_reg;
            end else begin
                pos_next = pos_reg - 1'b1;
            end
        end

        // home comes after the step, so it wins a tie in reset mode 1
        if (evt.home && ctl_reg.counter_wrap_sel) begin
            pos_next = '0;
        end

        // the error bit is sticky; only a reset clears it
        if (evt.phase_err) begin
            err_next = 1'b1;
        end

        // predivider and accumulator
        if (run && ctl_reg.vel_en && evt.step) begin
            pre_next = (pre_reg == pre_lim) ? 7'h00 : 7'(pre_reg + 7'h01);
        end
        if (vel_tick) begin
            acc_next = edge_accumulator + 32'h1;
        end

        // period timer
        if (run && ctl_reg.vel_en) begin
            if (expire) begin
                timer_next = period_reload_value;
                speed_next = acc_next;
                acc_next   = 32'h0;
            end else begin
                timer_next = timer_reg - 32'h1;
            end
        end

        // a software write wins over a hardware update of the same cycle, except an interrupt clear, which loses to new events
        // register writes, byte-lane merged
        if (wr_go) begin
            unique case (avs_address_i)
                `QEI_CTL_OFS: begin
                    wd       = ({20'h0, ctl_reg} & ~wmask) | (avs_writedata_i & wmask);
                    ctl_next = qei_ctl_t'(wd[11:0]);
                end
                `QEI_POS_OFS: begin
                    wd       = (32'(pos_reg) & ~wmask) | (avs_writedata_i & wmask);
                    pos_next = wd[PW-1:0];
                end
                `QEI_MAXPOS_OFS: begin
                    wd         = (32'(position_limit_reg) & ~wmask) | (avs_writedata_i & wmask);
                    limit_next = wd[PW-1:0];
                end
                `QEI_LOAD_OFS: begin
                    load_next  = (period_reload_value & ~wmask) | (avs_writedata_i & wmask);
                    timer_next = load_next;
                end
                `QEI_INTEN_OFS: begin
                    inten_next = avs_byteenable_i[0] ? avs_writedata_i[3:0] : inten_reg;
                end
                `QEI_PINSEL_OFS: begin
                    pinsel_next = avs_byteenable_i[0] ? avs_writedata_i[0] : pin_function_select_reg;
                end
                default: begin
                end
            endcase
        end

        // reads; unmapped offsets answer zero
        if (rd_go) begin
            unique case (avs_address_i)
                `QEI_CTL_OFS:    rdata_next = {20'h0, ctl_reg};
                `QEI_STAT_OFS:   rdata_next = {30'h0, dir_reg, err_reg};
                `QEI_POS_OFS:    rdata_next = 32'(pos_reg);
                `QEI_MAXPOS_OFS: rdata_next = 32'(position_limit_reg);
                `QEI_LOAD_OFS:   rdata_next = period_reload_value;
                `QEI_TIME_OFS:   rdata_next = timer_reg;
                `QEI_COUNT_OFS:  rdata_next = edge_accumulator;
                `QEI_SPEED_OFS:  rdata_next = period_edge_result;
                `QEI_INTEN_OFS:  rdata_next = {28'h0, inten_reg};
                `QEI_RIS_OFS:    rdata_next = {28'h0, ris_reg};
                `QEI_ISC_OFS:    rdata_next = {28'h0, ris_reg & inten_reg};
                `QEI_PINSEL_OFS: rdata_next = {31'h0, pin_function_select_reg};
                default:         rdata_next = 32'h0;
            endcase
        end

        // new events win over a clear in the same cycle
        ris_next = (ris_reg & ~clr_bits) | evt_bits;
    end

    // read data leave a flop and stand until the next read is captured
    assign avs_readdata_o = rdata_reg;

    // interrupt only for unmasked pending sources
    assign irq_o       = |(ris_reg & inten_reg);
    assign direction_o = dir_reg;

    // registers only
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_reg                 <= qei_ctl_t'(`QEI_CTL_RST);
            pin_function_select_reg <= 1'b0;
            pos_reg                 <= '0;
            position_limit_reg      <= '0;
            period_reload_value     <= `QEI_WORD_RST;
            timer_reg               <= `QEI_WORD_RST;
            edge_accumulator        <= `QEI_WORD_RST;
            period_edge_result      <= `QEI_WORD_RST;
            pre_reg                 <= 7'h00;
            inten_reg               <= 4'h0;
            ris_reg                 <= 4'h0;
            dir_reg                 <= 1'b0;
            err_reg                 <= 1'b0;
            ack_reg                 <= 1'b0;
            rdata_reg               <= `QEI_WORD_RST;
        end else begin
            ctl_reg                 <= ctl_next;
            pin_function_select_reg <= pinsel_next;
            pos_reg                 <= pos_next;
            position_limit_reg      <= limit_next;
            period_reload_value     <= load_next;
            timer_reg               <= timer_next;
            edge_accumulator        <= acc_next;
            period_edge_result      <= speed_next;
            pre_reg                 <= pre_next;
            inten_reg               <= inten_next;
            ris_reg                 <= ris_next;
            dir_reg                 <= dir_next;
            err_reg                 <= err_next;
            ack_reg                 <= ack_next;
            rdata_reg               <= rdata_next;
        end
    end
endmodule
`default_nettype wire

// ==== sim/qei_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "qei_map.svh"
// sees only the top ports: bus handshake, readback and direction timing
module qei_monitor (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    // encoder pins
    input wire logic        quad_input_first_i,
    input wire logic        quad_input_second_i,
    input wire logic        home_pulse_in_i,
    // avalon-mm slave
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // interrupt and status
    input wire logic        irq_o,
    input wire logic        direction_o
);
    logic [2:0] pins_reg;
    logic [2:0] pins_next;
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;

    // cycles since a pin moved or a register was written, saturating
    always_comb begin
        pins_next  = {home_pulse_in_i, quad_input_second_i, quad_input_first_i};
        quiet_next = (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
        if ((pins_next != pins_reg) || avs_write_i) begin
            quiet_next = 4'h0;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_reg  <= 3'h0;
            quiet_reg <= 4'hf;
        end else begin
            pins_reg  <= pins_next;
            quiet_reg <= quiet_next;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // one completed read at a given word index
    sequence s_rd_done(logic [3:0] ofs);
        avs_read_i && !avs_waitrequest_o && (avs_address_i == ofs);
    endsequence
    // a read completes and the bus goes idle next cycle
    sequence s_rd_then_idle;
        (avs_read_i && !avs_waitrequest_o) ##1 !(avs_read_i || avs_write_i);
    endsequence

    a_fresh_wait: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("new request not stalled on its first cycle");
    a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("stall longer than one cycle");
    a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("stall while idle");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 4'hb
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    a_data_hold: assert property (s_rd_then_idle |-> $stable(avs_readdata_o))
        else $error("read data did not stand");
    a_irq_masked: assert property (s_rd_done(`QEI_ISC_OFS) |->
        $past(irq_o) == (avs_readdata_o[3:0] != 4'h0))
        else $error("irq disagrees with masked status");
    a_stat_dir: assert property (s_rd_done(`QEI_STAT_OFS) |->
        avs_readdata_o[1] == $past(direction_o))
        else $error("status direction differs from pin");
    a_reset_quiet: assert property ($rose(resetn_i) |-> !irq_o && !direction_o)
        else $error("outputs active after reset");
    a_dir_cause: assert property ($changed(direction_o) |-> quiet_reg <= 4'h6)
        else $error("direction moved without a recent pin edge");
endmodule

bind qei_top qei_monitor u_mon (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .quad_input_first_i(quad_input_first_i), .quad_input_second_i(quad_input_second_i),
    .home_pulse_in_i(home_pulse_in_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .direction_o(direction_o));
`default_nettype wire

// ==== sim/qei_enc_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// behavioural encoder: quadrature moves, forced fault, step/direction, home
module qei_enc_model (
    // clock
    input  wire logic mclk_i,
    // encoder lines
    output var logic  a_o,
    output var logic  b_o,
    output var logic  home_o
);
    int         gap = 4; // edges at least four cycles apart keep the rate limit
    logic [1:0] idx = 2'h0;

    initial begin
        a_o    = 1'b0;
        b_o    = 1'b0;
        home_o = 1'b0;
    end

    // gray order 00,10,11,01: going up the first line leads
    task automatic move(input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            idx = up ? idx + 2'h1 : idx - 2'h1;
            @(posedge mclk_i);
            a_o <= (idx == 2'h1) || (idx == 2'h2);
            b_o <= idx[1];
            repeat (gap) @(posedge mclk_i);
        end
    endtask

    // both lines flip at once, only when the bench asks for it
    task automatic glitch();
        idx = idx + 2'h2;
        @(posedge mclk_i);
        a_o <= ~a_o;
        b_o <= ~b_o;
        repeat (gap) @(posedge mclk_i);
    endtask

    // first line clocks steps, second holds direction
    task automatic step(input int n, input logic dn);
        @(posedge mclk_i);
        a_o <= 1'b0;
        b_o <= dn;
        idx = dn ? 2'h3 : 2'h0;
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge mclk_i);
            a_o <= 1'b1;
            repeat (gap) @(posedge mclk_i);
            a_o <= 1'b0;
        end
        repeat (gap) @(posedge mclk_i);
    endtask

    // one home pulse, gap cycles wide
    task automatic pulse_home();
        @(posedge mclk_i);
        home_o <= 1'b1;
        repeat (gap) @(posedge mclk_i);
        home_o <= 1'b0;
        repeat (gap) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "qei_map.svh"
// self-checking bench: bus tasks, one task per scenario, one verdict
module tb_top;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        pa;
    logic        pb;
    logic        ph;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wrs = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq;
    logic        dir;
    logic [31:0] rdq;
    int          fails = 0;
    int          tests_run = 0;

    qei_top dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .quad_input_first_i(pa),
        .quad_input_second_i(pb), .home_pulse_in_i(ph), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wrs), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq), .direction_o(dir));
    qei_enc_model u_enc (.mclk_i(mclk_i), .a_o(pa), .b_o(pb), .home_o(ph));

    // 50 ns period
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end

    // the request stands until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk_i);
        adr <= a;
        wd  <= d;
        wrs <= w;
        rd  <= !w;
        do @(posedge mclk_i); while (waitreq !== 1'b0);
        q = rdata;
        wrs <= 1'b0;
        rd  <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        acc(1'b1, a, d, rdq);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, rdq);
        chk(rdq, exp);
    endtask
    // reads raw status until bit b sets, bounded by the read count
    task automatic poll(input int b);
        rdq = 32'h0;
        for (int k = 0; k < 100 && rdq[b] !== 1'b1; k++) begin
            acc(1'b0, `QEI_RIS_OFS, 32'h0, rdq);
        end
        chk(32'(rdq[b]), 32'h1);
    endtask

    // reset values, refused accesses, pins ignored until routed
    task automatic t_reset();
        rchk(`QEI_CTL_OFS, 32'h0);
        rchk(`QEI_STAT_OFS, 32'h0);
        rchk(4'hc, 32'h0);
        wr(`QEI_SPEED_OFS, 32'h5);
        rchk(`QEI_SPEED_OFS, 32'h0);
        wr(`QEI_CTL_OFS, 32'h9);
        u_enc.move(4, 1'b1);
        rchk(`QEI_POS_OFS, 32'h0);
        $display("reset test done");
    endtask
    // counting sense, capture modes, swap
    task automatic t_quad();
        wr(`QEI_MAXPOS_OFS, 32'hf);
        wr(`QEI_PINSEL_OFS, 32'h1);
        u_enc.move(4, 1'b1);
        rchk(`QEI_POS_OFS, 32'h4);
        wr(`QEI_CTL_OFS, 32'h1);
        u_enc.move(4, 1'b1);
        rchk(`QEI_POS_OFS, 32'h6);
        wr(`QEI_CTL_OFS, 32'h9);
        u_enc.move(2, 1'b0);
        rchk(`QEI_POS_OFS, 32'h4);
        rchk(`QEI_STAT_OFS, 32'h2);
        wr(`QEI_CTL_OFS, 32'hb);
        u_enc.move(2, 1'b1);
        rchk(`QEI_POS_OFS, 32'h2);
        chk(32'(dir), 32'h1);
        $display("quadrature test done");
    endtask
    // wrap at both ends, direction change, home in both reset modes
    task automatic t_wrap();
        wr(`QEI_CTL_OFS, 32'h9);
        wr(`QEI_POS_OFS, 32'hf);
        wr(`QEI_ISC_OFS, 32'hf);
        u_enc.move(1, 1'b1);
        rchk(`QEI_POS_OFS, 32'h0);
        u_enc.move(1, 1'b0);
        rchk(`QEI_POS_OFS, 32'hf);
        rchk(`QEI_RIS_OFS, 32'h4);
        u_enc.pulse_home();
        rchk(`QEI_POS_OFS, 32'hf);
        rchk(`QEI_RIS_OFS, 32'h5);
        wr(`QEI_CTL_OFS, 32'h19);
        u_enc.pulse_home();
        rchk(`QEI_POS_OFS, 32'h0);
        u_enc.move(1, 1'b0);
        rchk(`QEI_POS_OFS, 32'hf);
        wr(`QEI_CTL_OFS, 32'h819);
        rchk(`QEI_CTL_OFS, 32'h819);
        rchk(`QEI_POS_OFS, 32'h0);
        wr(`QEI_CTL_OFS, 32'h19);
        wr(`QEI_POS_OFS, 32'hf);
        $display("wrap test done");
    endtask
    // forced phase fault, then mask, pending and clear of its interrupt
    task automatic t_err();
        wr(`QEI_ISC_OFS, 32'hf);
        u_enc.glitch();
        rchk(`QEI_POS_OFS, 32'hf);
        acc(1'b0, `QEI_RIS_OFS, 32'h0, rdq);
        chk(32'(rdq[3]), 32'h1);
        chk(32'(irq), 32'h0);
        wr(`QEI_INTEN_OFS, 32'h8);
        rchk(`QEI_ISC_OFS, 32'h8);
        chk(32'(irq), 32'h1);
        wr(`QEI_ISC_OFS, 32'h8);
        rchk(`QEI_ISC_OFS, 32'h0);
        chk(32'(irq), 32'h0);
        $display("fault test done");
    endtask
    // step/direction mode
    task automatic t_step();
        wr(`QEI_CTL_OFS, 32'h5);
        wr(`QEI_POS_OFS, 32'h5);
        u_enc.step(3, 1'b0);
        rchk(`QEI_POS_OFS, 32'h8);
        u_enc.step(2, 1'b1);
        rchk(`QEI_POS_OFS, 32'h6);
        $display("step test done");
    endtask
    // velocity over a 200-cycle period with divide-by-2, then an idle period
    task automatic t_vel();
        wr(`QEI_CTL_OFS, 32'h9);
        wr(`QEI_LOAD_OFS, 32'hc7);
        wr(`QEI_CTL_OFS, 32'h69);
        wr(`QEI_ISC_OFS, 32'hf);
        u_enc.move(8, 1'b1);
        poll(1);
        rchk(`QEI_SPEED_OFS, 32'h4);
        rchk(`QEI_COUNT_OFS, 32'h0);
        wr(`QEI_ISC_OFS, 32'h2);
        poll(1);
        rchk(`QEI_SPEED_OFS, 32'h0);
        $display("velocity test done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_quad();
        t_wrap();
        t_err();
        t_step();
        t_vel();
        report_and_stop();
    end

    // whole run needs under a thousand cycles; far beyond that is a hang
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
`default_nettype wire
